// ### bench/epbs_switch_model.sv
// Stand-in for the power switch drivers on the four bridge outputs
`timescale 1ns/10ps
module epbs_switch_model import epbs_pkg::*; (
  input wire epbs_pins_t pins,
  output logic [3:0] level
);
  // Pull-downs keep a switch off whenever its pin is not driven
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      level[i] = pins.oe[i] ? pins.val[i] : 1'b0;
    end
  end
endmodule

// ### bench/epbs_top_tb.sv
// Self-checking bench for the bridge PWM unit
`timescale 1ns/10ps
module epbs_top_tb import epbs_pkg::*;;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
  logic [7:0] awaddr, araddr, rv, r2;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, lvl, st;
  logic [1:0] bresp, rresp, rr, wb;
  epbs_pmode_t pmode;
  logic fail_safe_enable, clock_fail, sd, pa, pb;
  epbs_trip_t trip;
  epbs_pins_t pins, p;
  epbs_csrc_t clock_source;
  int err_total, comparisons, cycles, ha, hb, n;
  // Address, reset value, written value, read-back value
  logic [7:0] rows [12][4] = '{'{A_COUNT, 8'h00, 8'h00, 8'h00}, '{A_LIMIT, 8'hff, 8'h05, 8'h05},
    '{A_TCTL, 8'h00, 8'hf8, 8'h78}, '{A_DUTY, 8'h00, 8'h3c, 8'h3c}, '{A_SHADOW, 8'h00, 8'h5a, 8'h00},
    '{A_MODE, 8'h00, 8'ha5, 8'ha5}, '{A_SDCTL, 8'h00, 8'h25, 8'h25}, '{A_DBCFG, 8'h00, 8'h85, 8'h85},
    '{A_FLAGS, 8'h00, 8'h00, 8'h00}, '{A_MASK, 8'h00, 8'h82, 8'h82}, '{A_DIR, 8'h0f, 8'h0f, 8'h0f},
    '{8'h30, 8'h00, 8'h11, 8'h00}};
  // Mode, high cycles of output_a and output_b in 64 cycles at limit 3, duty 1 (1.75 in the half bridge row)
  logic [7:0] pol [6][3] = '{'{8'h0c, 8'h10, 8'h00}, '{8'h0e, 8'h30, 8'h00}, '{8'h0d, 8'h10, 8'h40},
    '{8'h4f, 8'h00, 8'h40}, '{8'hcc, 8'h00, 8'h10}, '{8'hbc, 8'h0c, 8'h10}};
  epbs_pmode_t pm [3] = '{PM_PIDLE, PM_LOWP, PM_SLEEP};
  epbs_csrc_t cs [3] = '{CS_PRI, CS_LOWP, CS_NONE};

  // Small dividers keep the low-power and RC phases short
  epbs_top #(.LP_DIV(8'h02), .RC_DIV(8'h02)) dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .pmode(pmode),
    .fail_safe_enable(fail_safe_enable), .clock_fail(clock_fail), .trip(trip), .pins(pins), .irq(irq),
    .clock_source(clock_source));
  epbs_switch_model drv (.pins(pins), .level(lvl));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Each valid drops once, at the edge that takes it, so a following call can raise it cleanly
    do begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!bvalid);
    wb = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata[7:0];
    r = rresp;
  endtask

  initial begin
    {aresetn, awvalid, wvalid, arvalid, fail_safe_enable, clock_fail} = '0;
    // Responses are always accepted, so the ready lines never toggle between transfers
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    pmode = PM_RUN;
    trip = '0;
    do_reset();
    chk({4'h0, pins.oe}, 8'h00);
    foreach (rows[i]) begin
      rd(rows[i][0], rv, rr);
      chk(rv, rows[i][1]);
      wr(rows[i][0], rows[i][2]);
      chk({6'h00, wb}, {6'h00, (rows[i][0] == 8'h30) ? RESP_SLVERR : RESP_OKAY});
      rd(rows[i][0], rv, rr);
      chk(rv, rows[i][3]);
      chk({6'h00, rr}, {6'h00, (rows[i][0] == 8'h30) ? RESP_SLVERR : RESP_OKAY});
    end
    do_reset();
    rd(A_LIMIT, rv, rr);
    chk(rv, 8'hff);
    // Start-up order: pins as inputs, period, control, duty, hold, timer
    wr(A_DIR, 8'h0f);
    wr(A_LIMIT, 8'h03);
    wr(A_MODE, 8'h0c);
    wr(A_DUTY, 8'h01);
    wr(A_SDCTL, 8'h80);
    wr(A_FLAGS, 8'h02);
    wr(A_MASK, 8'h02);
    wr(A_TCTL, 8'h04);
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge aclk);
      n++;
    end
    chk({7'h00, n >= 12 && n <= 20}, 8'h01);
    chk({4'h0, pins.oe}, 8'h00);
    wr(A_DBCFG, 8'h01);
    foreach (pol[i]) begin
      // Polarity only changes while the pins are inputs
      wr(A_DIR, 8'h0f);
      wr(A_MODE, pol[i][0]);
      wr(A_DIR, 8'h00);
      wr(A_SDCTL, 8'h00);
      wr(A_FLAGS, 8'h02);
      while (irq !== 1'b1) @(posedge aclk);
      ha = 0;
      hb = 0;
      repeat (64) begin
        @(posedge aclk);
        ha += lvl[0];
        hb += lvl[1];
      end
      chk(8'(ha), pol[i][1]);
      chk(8'(hb), pol[i][2]);
    end
    wr(A_MODE, 8'h0c);
    for (int c = 0; c < 8; c++) begin
      st = c[0] ? 4'h6 : 4'h1;
      sd = (c != 0);
      trip <= epbs_trip_t'(~c[2:0]);
      wr(A_SDCTL, {1'b0, c[2:0], st});
      repeat (6) @(posedge aclk);
      rd(A_SDCTL, rv, rr);
      chk(rv, {1'b0, c[2:0], st});
      trip <= epbs_trip_t'(c[2:0]);
      repeat (6) @(posedge aclk);
      pa = (st[3:2] == 2'b01);
      pb = (st[1:0] == 2'b01);
      if (sd) begin
        chk({4'h0, pins.oe}, {4'h0, !st[1], !st[3], !st[1], !st[3]});
        chk({4'h0, lvl}, {4'h0, pb, pa, pb, pa});
      end
      wr(A_SDCTL, {1'b0, c[2:0], st});
      rd(A_SDCTL, rv, rr);
      chk({7'h00, rv[7]}, {7'h00, sd});
      trip <= '0;
      wr(A_SDCTL, 8'h00);
    end
    // Auto restart: the shutdown flag follows the comparator level and clears by itself
    wr(A_DBCFG, 8'h81);
    wr(A_SDCTL, 8'h10);
    trip <= 3'b001;
    repeat (6) @(posedge aclk);
    rd(A_SDCTL, rv, rr);
    chk(rv, 8'h90);
    trip <= '0;
    repeat (6) @(posedge aclk);
    rd(A_SDCTL, rv, rr);
    chk(rv, 8'h10);
    wr(A_LIMIT, 8'hff);
    foreach (pm[i]) begin
      pmode <= pm[i];
      repeat (4) @(posedge aclk);
      chk({6'h00, clock_source}, {6'h00, cs[i]});
      rd(A_COUNT, rv, rr);
      p = pins;
      repeat (24) @(posedge aclk);
      rd(A_COUNT, r2, rr);
      chk({7'h00, rv == r2}, {7'h00, i == 2});
      if (i == 2) chk(pins, p);
    end
    pmode <= PM_RUN;
    clock_fail <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({6'h00, clock_source}, {6'h00, CS_PRI});
    wr(A_MASK, 8'h80);
    fail_safe_enable <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({6'h00, clock_source}, {6'h00, CS_RC});
    chk({7'h00, irq}, 8'h01);
    rd(A_FLAGS, rv, rr);
    chk({7'h00, rv[7]}, 8'h01);
    clock_fail <= 1'b0;
    do_reset();
    chk({4'h0, pins.oe}, 8'h00);
    chk({6'h00, clock_source}, {6'h00, CS_PRI});
    chk({7'h00, irq}, 8'h00);
    report_and_stop();
  end
endmodule

// ### design/epbs_clk_tick.sv
// Clock source selection and base tick of the period timer
`timescale 1ns/10ps
module epbs_clk_tick import epbs_pkg::*; #(
  parameter logic [7:0] LP_DIV = 8'h08,
  parameter logic [7:0] RC_DIV = 8'h04
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire epbs_pmode_t pmode,
  input wire logic failover,
  output epbs_csrc_t src,
  output logic base_tick
);
  epbs_csrc_t next_src;
  logic [7:0] cnt;
  logic [7:0] last;

  always_comb begin
    if (pmode == PM_SLEEP) begin
      next_src = CS_NONE;
    end else if (failover) begin
      next_src = CS_RC;
    end else if (pmode == PM_LOWP) begin
      next_src = CS_LOWP;
    end else begin
      next_src = CS_PRI;
    end
  end

  assign last = (next_src == CS_LOWP) ? LP_DIV - 8'h01 : RC_DIV - 8'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src <= CS_PRI;
      cnt <= RV_ZERO;
      base_tick <= 1'b0;
    end else begin
      src <= next_src;
      base_tick <= (next_src == CS_PRI) || ((next_src == CS_LOWP || next_src == CS_RC) && cnt == last);
      if (next_src == CS_PRI || next_src == CS_NONE || cnt == last) begin
        cnt <= RV_ZERO;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end

  a_idle_full_rate: assert property (@(posedge aclk) disable iff (!aresetn)
    (pmode == PM_PIDLE && !failover) |=> base_tick)
    else $error("primary idle lost a base tick");
  a_lowp_divided: assert property (@(posedge aclk) disable iff (!aresetn)
    (base_tick && src == CS_LOWP && pmode == PM_LOWP && !failover) |=> !base_tick)
    else $error("low power clock not divided");
endmodule

// ### design/epbs_top.sv
// Enhanced bridge PWM unit with period timer, shutdown and register slave
// Contract
// - Mode bits 1:0 set per-pair output polarity
// - Period flag sets as second period begins
// - Duty comes from low byte plus bits 5:4
// - Half bridge deadband from config bits 6:0
// - Shutdown-active flag lives at shutdown bit 7
// - Auto-restart enable is config bit 7
// - Sleep freezes timer and state, pins hold
// - Primary idle keeps full-rate PWM clock
// - Other low-power modes clock timer differently
// - Clock failure switches to RC, sets flag
// - Reset forces inputs and register reset values
// - Source field: 0 off, OR of three
// - Shutdown drives each pair low, high, tristate
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module epbs_top import epbs_pkg::*; #(
  parameter logic [7:0] LP_DIV = 8'h08,
  parameter logic [7:0] RC_DIV = 8'h04
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire epbs_pmode_t pmode,
  input wire logic fail_safe_enable,
  input wire logic clock_fail,
  input wire epbs_trip_t trip,
  output epbs_pins_t pins,
  output logic irq,
  output epbs_csrc_t clock_source
);
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= A_CLK);
  endfunction

  // Bus slave state
  logic aw_full, w_full, wr, wsel;
  logic [7:0] wa, wd;
  logic ws;
  logic [7:0] rd_word;

  // Unit registers
  logic [7:0] count, limit, duty_lo, shadow_hi, mode_ctl, db_cfg, flags, mask;
  logic [6:0] tctl, sd_cfg;
  logic [1:0] shadow_fine;
  logic [3:0] dir;
  logic sd_flag, live, failover;

  // Pin synchronisers
  logic [4:0] sy1, sy2;
  epbs_trip_t trip_s;
  logic fs_s, fail_s;

  // Timer and waveform
  logic base_tick, run, adv, step, wrap, pwm_on, raw, prev_raw, hold, sd_now, osf_ev;
  logic [5:0] sub, sub_last;
  logic [1:0] fine;
  logic [6:0] db_cnt;
  logic a_on, b_on;
  logic [3:0] act, pv, po;
  epbs_cfg_t cfg;

  assign awready = !aw_full;
  assign wready = !w_full;
  assign arready = !rvalid;
  assign wr = aw_full && w_full && !bvalid;
  assign wsel = wr && ws;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      wa <= RV_ZERO;
      wd <= RV_ZERO;
      ws <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_full <= 1'b1;
        wa <= awaddr;
      end
      if (wvalid && wready) begin
        w_full <= 1'b1;
        wd <= wdata[7:0];
        ws <= wstrb[0];
      end
      if (wr) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    case (araddr)
      A_COUNT: rd_word = count;
      A_LIMIT: rd_word = limit;
      A_TCTL: rd_word = {1'b0, tctl};
      A_DUTY: rd_word = duty_lo;
      A_SHADOW: rd_word = shadow_hi;
      A_MODE: rd_word = mode_ctl;
      A_SDCTL: rd_word = {sd_flag, sd_cfg};
      A_DBCFG: rd_word = db_cfg;
      A_FLAGS: rd_word = flags;
      A_MASK: rd_word = mask;
      A_DIR: rd_word = {4'h0, dir};
      A_CLK: rd_word = {5'h00, failover, clock_source};
      default: rd_word = RV_ZERO;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_word};
      rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Control registers; all return to reset values on any reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit <= RV_LIMIT;
      tctl <= RV_TCTL;
      duty_lo <= RV_ZERO;
      mode_ctl <= RV_ZERO;
      sd_cfg <= RV_TCTL;
      db_cfg <= RV_ZERO;
      mask <= RV_ZERO;
      dir <= RV_DIR;
    end else if (wsel) begin
      if (wa == A_LIMIT) limit <= wd;
      if (wa == A_TCTL) tctl <= wd[6:0];
      if (wa == A_DUTY) duty_lo <= wd;
      if (wa == A_MODE) mode_ctl <= wd;
      if (wa == A_SDCTL) sd_cfg <= wd[6:0];
      if (wa == A_DBCFG) db_cfg <= wd;
      if (wa == A_MASK) mask <= wd;
      if (wa == A_DIR) dir <= wd[3:0];
    end
  end

  // Two flops on the trip, clock_fail and fail_safe_enable inputs before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1 <= 5'h00;
      sy2 <= 5'h00;
    end else begin
      sy1 <= {fail_safe_enable, clock_fail, trip};
      sy2 <= sy1;
    end
  end
  assign trip_s = epbs_trip_t'(sy2[2:0]);
  assign fail_s = sy2[3];
  assign fs_s = sy2[4];

  epbs_clk_tick #(
    .LP_DIV(LP_DIV),
    .RC_DIV(RC_DIV)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .pmode(pmode),
    .failover(failover),
    .src(clock_source),
    .base_tick(base_tick)
  );

  // Failover is sticky until reset, as the primary clock is not trusted again
  assign osf_ev = fs_s && fail_s && !failover;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      failover <= 1'b0;
    end else if (osf_ev) begin
      failover <= 1'b1;
    end
  end

  // Timer prescale also picks which sub bits extend the count for duty
  always_comb begin
    case (tctl[F_PRE +: 2])
      2'b00: begin
        sub_last = PRE_LAST_1;
        fine = sub[1:0];
      end
      2'b01: begin
        sub_last = PRE_LAST_4;
        fine = sub[3:2];
      end
      default: begin
        sub_last = PRE_LAST_16;
        fine = sub[5:4];
      end
    endcase
  end

  assign run = tctl[F_RUN];
  assign adv = base_tick && run;
  assign step = adv && (sub == sub_last);
  assign wrap = step && (count == limit);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub <= 6'h00;
      count <= RV_ZERO;
    end else begin
      if (!run) begin
        sub <= 6'h00;
      end else if (adv) begin
        sub <= (sub == sub_last) ? 6'h00 : sub + 6'h01;
      end
      if (wsel && wa == A_COUNT) begin
        count <= wd;
      end else if (step) begin
        count <= wrap ? RV_ZERO : count + 8'h01;
      end
    end
  end

  // Duty is double buffered so a period never sees a torn value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow_hi <= RV_ZERO;
      shadow_fine <= 2'b00;
    end else if (wrap) begin
      shadow_hi <= duty_lo;
      shadow_fine <= mode_ctl[F_DC +: 2];
    end
  end

  // Flags: bit 1 period, bit 7 oscillator fail; a set beats a clearing write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= RV_ZERO;
    end else begin
      flags[F_PTF] <= wrap || (flags[F_PTF] && !(wsel && wa == A_FLAGS && wd[F_PTF]));
      flags[F_OSF] <= osf_ev || (flags[F_OSF] && !(wsel && wa == A_FLAGS && wd[F_OSF]));
    end
  end
  assign irq = |(flags & mask);

  // Shutdown sources are ORed by the select field; zero disables
  assign sd_now = |(sd_cfg[F_SRC +: 3] & {trip_s.ext, trip_s.cmp2, trip_s.cmp1});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sd_flag <= 1'b0;
    end else if (sd_now) begin
      sd_flag <= 1'b1;
    end else if (wsel && wa == A_SDCTL) begin
      sd_flag <= wd[F_SDA];
    end else if (db_cfg[F_RST]) begin
      sd_flag <= 1'b0;
    end
  end

  // Release waits for a period start unless the last one passed with no shutdown; a shutdown within one period releases at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      live <= 1'b0;
    end else if (wrap) begin
      live <= !sd_flag;
    end
  end

  assign pwm_on = (mode_ctl[F_PWM +: 2] == 2'b11);
  assign cfg = epbs_cfg_t'(mode_ctl[F_CFG +: 2]);
  assign raw = pwm_on && ({shadow_hi, shadow_fine} > {count, fine});
  assign hold = pwm_on && (sd_flag || sd_now || !live);

  // Deadband delays only the inactive-to-active edge, in instruction cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_raw <= 1'b0;
      db_cnt <= RV_TCTL;
    end else begin
      prev_raw <= raw;
      if (raw != prev_raw) begin
        db_cnt <= db_cfg[6:0];
      end else if (adv && sub[1:0] == TCY_LAST && db_cnt != 7'h00) begin
        db_cnt <= db_cnt - 7'h01;
      end
    end
  end
  assign a_on = raw && prev_raw && (db_cnt == 7'h00);
  assign b_on = !raw && !prev_raw && (db_cnt == 7'h00);

  always_comb begin
    case (cfg)
      CFG_SINGLE: act = {3'b000, raw};
      CFG_FWD: act = {raw, 2'b00, 1'b1};
      CFG_HALF: act = {2'b00, b_on, a_on};
      CFG_REV: act = {1'b0, 1'b1, raw, 1'b0};
      default: act = 4'h0;
    endcase
  end

  // Index 0 and 2 form pair A/C, index 1 and 3 pair B/D
  for (genvar i = 0; i < 4; i++) begin : g_pin
    localparam int SD = (i % 2 == 0) ? F_PAC : F_PBD;
    localparam int PL = (i % 2 == 0) ? F_POL_AC : F_POL_BD;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pv[i] <= 1'b0;
        po[i] <= 1'b0;
      end else begin
        pv[i] <= hold ? sd_cfg[SD] : (pwm_on && (act[i] ^ mode_ctl[PL]));
        po[i] <= !dir[i] && !(hold && sd_cfg[SD + 1]);
      end
    end
  end
  assign pins = '{val: pv, oe: po};

  a_pol_fwd_ac: assert property (@(posedge aclk) disable iff (!aresetn)
    (pwm_on && !hold && cfg == CFG_FWD) |=> pv[0] == !$past(mode_ctl[F_POL_AC]))
    else $error("pair A/C polarity wrong");
  a_period_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    wrap |=> flags[F_PTF])
    else $error("period flag missed at period start");
  a_duty_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    wrap |=> shadow_hi == $past(duty_lo) && shadow_fine == $past(mode_ctl[F_DC +: 2]))
    else $error("duty not latched at period start");
  a_deadband_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg == CFG_HALF && raw && !prev_raw && db_cfg[6:0] != 7'h00) |-> !a_on ##1 !a_on)
    else $error("deadband not applied");
  a_auto_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    (sd_flag && !sd_now && db_cfg[F_RST] && !(wsel && wa == A_SDCTL)) |=> !sd_flag)
    else $error("auto restart did not clear shutdown");
  a_ext_source: assert property (@(posedge aclk) disable iff (!aresetn)
    (trip_s.ext && sd_cfg[F_SRC + 2]) |=> sd_flag)
    else $error("external source did not shut down");
  a_sleep_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
    (pmode == PM_SLEEP)[*2] ##0 !(wsel && wa == A_COUNT) |=> $stable(count))
    else $error("timer moved in sleep");
  a_failover_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    osf_ev |=> failover && flags[F_OSF] ##1 clock_source != CS_PRI)
    else $error("clock failure not handled");
  a_reset_inputs: assert property (@(posedge aclk)
    !aresetn |=> po == 4'h0 && dir == RV_DIR && mode_ctl == RV_ZERO)
    else $error("reset state wrong");
  a_sd_pair_ac: assert property (@(posedge aclk) disable iff (!aresetn)
    (hold && !sd_cfg[F_PAC + 1]) |=> pv[0] == $past(sd_cfg[F_PAC]) && pv[2] == $past(sd_cfg[F_PAC]))
    else $error("pair A/C shutdown level wrong");
endmodule

// ### inc/epbs_pkg.sv
// Register map, field positions, timing counts and types of the bridge PWM unit
package epbs_pkg;
  // Register byte offsets
  localparam logic [7:0] A_COUNT = 8'h00;
  localparam logic [7:0] A_LIMIT = 8'h04;
  localparam logic [7:0] A_TCTL = 8'h08;
  localparam logic [7:0] A_DUTY = 8'h0c;
  localparam logic [7:0] A_SHADOW = 8'h10;
  localparam logic [7:0] A_MODE = 8'h14;
  localparam logic [7:0] A_SDCTL = 8'h18;
  localparam logic [7:0] A_DBCFG = 8'h1c;
  localparam logic [7:0] A_FLAGS = 8'h20;
  localparam logic [7:0] A_MASK = 8'h24;
  localparam logic [7:0] A_DIR = 8'h28;
  localparam logic [7:0] A_CLK = 8'h2c;
  // Field positions
  localparam int F_PRE = 0;
  localparam int F_RUN = 2;
  localparam int F_POL_BD = 0;
  localparam int F_POL_AC = 1;
  localparam int F_PWM = 2;
  localparam int F_DC = 4;
  localparam int F_CFG = 6;
  localparam int F_PBD = 0;
  localparam int F_PAC = 2;
  localparam int F_SRC = 4;
  localparam int F_SDA = 7;
  localparam int F_RST = 7;
  localparam int F_PTF = 1;
  localparam int F_OSF = 7;
  // Reset values
  localparam logic [7:0] RV_ZERO = 8'h00;
  localparam logic [7:0] RV_LIMIT = 8'hff;
  localparam logic [3:0] RV_DIR = 4'hf;
  localparam logic [6:0] RV_TCTL = 7'h00;
  // Timing: base ticks per instruction cycle and per timer step
  localparam logic [1:0] TCY_LAST = 2'h3;
  localparam logic [5:0] PRE_LAST_1 = 6'h03;
  localparam logic [5:0] PRE_LAST_4 = 6'h0f;
  localparam logic [5:0] PRE_LAST_16 = 6'h3f;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CFG_SINGLE = 2'b00, CFG_FWD = 2'b01, CFG_HALF = 2'b10, CFG_REV = 2'b11
  } epbs_cfg_t;
  typedef enum logic [1:0] {
    PM_RUN = 2'b00, PM_PIDLE = 2'b01, PM_LOWP = 2'b10, PM_SLEEP = 2'b11
  } epbs_pmode_t;
  typedef enum logic [1:0] {
    CS_PRI = 2'b00, CS_LOWP = 2'b01, CS_RC = 2'b10, CS_NONE = 2'b11
  } epbs_csrc_t;
  typedef struct packed {logic ext; logic cmp2; logic cmp1;} epbs_trip_t;
  typedef struct packed {logic [3:0] val; logic [3:0] oe;} epbs_pins_t;
endpackage
